// ==== src/cpi_cfg.svh ====
// Purpose: offsets, field positions, reset values for the clock/power interrupt block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: definitions only
`ifndef CPI_CFG_SVH
`define CPI_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CPI_ADDR_W 8
`define CPI_OFF_UNIT_IRQ_EN 8'h00
`define CPI_OFF_FLAGS 8'h04
`define CPI_OFF_TICK_PERIOD 8'h08
`define CPI_OFF_DROOP_CTRL 8'h0C
`define CPI_OFF_PTIMER_CTRL 8'h10
`define CPI_OFF_PTIMER_PERIOD 8'h14

// ----------------------------------------------------------------
// unit_irq_enable_register fields
// ----------------------------------------------------------------
`define CPI_EN_TICK 0
`define CPI_EN_PLL 1
`define CPI_EN_OSC 2
`define CPI_EN_TICK_SEL 3
`define CPI_EN_PSTOP 4
`define CPI_EN_OSC_KEEP 5
`define CPI_EN_OSC_ON 6

// ----------------------------------------------------------------
// flag register fields (flags write-one-to-clear, status read-only)
// ----------------------------------------------------------------
`define CPI_FL_TICK 0
`define CPI_FL_PLL 1
`define CPI_FL_OSC 2
`define CPI_FL_DROOP 3
`define CPI_FL_PTIMER 4
`define CPI_ST_PLL_LOCK 8
`define CPI_ST_OSC_UP 9
`define CPI_ST_DROOP 10

// ----------------------------------------------------------------
// periodic timer control fields
// ----------------------------------------------------------------
`define CPI_PT_ENABLE 0
`define CPI_PT_CLK_SEL 1
`define CPI_PT_IRQ_EN 2
`define CPI_PT_PIN_EN 3
`define CPI_PT_TRIM_LO 8
`define CPI_PT_TRIM_HI 13

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define CPI_RST_TICK_PERIOD 16'hFFFF
`define CPI_RST_PTIMER_PERIOD 16'hFFFF
`define CPI_RST_TRIM 6'h20
`define CPI_RESP_OKAY 2'h0
`define CPI_RESP_DECERR 2'h3

`endif

// ==== src/cpi_pkg.sv ====
// Purpose: types of the clock/power interrupt block
// Assumes: constants come from cpi_cfg.svh
// Notes: whole module state is one packed struct
package cpi_pkg;

    typedef struct packed {
        // bus slave
        logic aw_have_r;
        logic [7:0] aw_addr_r;
        logic w_have_r;
        logic [31:0] w_data_r;
        logic [3:0] w_strb_r;
        logic bvalid_r;
        logic [1:0] bresp_r;
        logic rvalid_r;
        logic [31:0] rdata_r;
        logic [1:0] rresp_r;
        // control
        logic tick_irq_enable_r;
        logic pll_settle_irq_enable_r;
        logic oscillator_change_irq_enable_r;
        logic tick_clock_select_r;
        logic pseudo_stop_select_r;
        logic osc_keep_in_stop_r;
        logic ext_oscillator_enable_r;
        logic supply_droop_irq_enable_r;
        logic periodic_timer_enable_r;
        logic periodic_timer_clock_select_r;
        logic periodic_timer_irq_enable_r;
        logic periodic_timer_pin_enable_r;
        logic [5:0] autonomous_clock_trim_r;
        logic [15:0] tick_period_r;
        logic [15:0] periodic_timer_period_r;
        // flags and status
        logic tick_flag_r;
        logic pll_settle_change_flag_r;
        logic oscillator_change_flag_r;
        logic supply_droop_flag_r;
        logic periodic_timer_flag_r;
        logic pll_lock_seen_r;
        logic oscillator_up_status_r;
        logic supply_droop_status_r;
        // counters and pin
        logic [15:0] tick_count_r;
        logic [15:0] ptimer_count_r;
        logic periodic_waveform_r;
    } cpi_state_t;

endpackage

// ==== src/cpi_irq.sv ====
// Purpose: interrupt logic of a clock, power and reset unit, AXI4-Lite register slave
// Assumes: slow clocks arrive as one-cycle enables synchronous to aclk
// Notes: irq outputs already gated by local enable and the cpu mask
`timescale 1ns/10ps
`include "cpi_cfg.svh"

module cpi_irq (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic internal_rc_tick,
    input wire logic external_oscillator_tick,
    input wire logic autonomous_rc_tick,
    input wire logic bus_clock_stopped,
    input wire logic stop_mode,
    input wire logic full_stop_mode,
    input wire logic full_performance_mode,
    input wire logic pll_lock,
    input wire logic pll_config_change,
    input wire logic supply_below_assert,
    input wire logic supply_above_deassert,
    input wire logic cpu_irq_mask,
    output logic periodic_tick_interrupt,
    output logic pll_settle_interrupt,
    output logic oscillator_change_interrupt,
    output logic supply_droop_interrupt,
    output logic periodic_timer_interrupt,
    output logic periodic_waveform_pin
);

    cpi_pkg::cpi_state_t s_r;
    cpi_pkg::cpi_state_t s_nxt;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // register index 0..5 from a byte address, 7 when unmapped
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        logic [2:0] idx;
        idx = 3'h7;
        case (addr & 8'hFC)
            `CPI_OFF_UNIT_IRQ_EN: idx = 3'h0;
            `CPI_OFF_FLAGS: idx = 3'h1;
            `CPI_OFF_TICK_PERIOD: idx = 3'h2;
            `CPI_OFF_DROOP_CTRL: idx = 3'h3;
            `CPI_OFF_PTIMER_CTRL: idx = 3'h4;
            `CPI_OFF_PTIMER_PERIOD: idx = 3'h5;
            default: idx = 3'h7;
        endcase
        return idx;
    endfunction

    // byte-lane merge of write data over an old word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // handshake outputs
    // ----------------------------------------------------------------
    // one write and one read at a time: channels close while an answer waits
    assign s_axi_awready = !s_r.aw_have_r && !s_r.bvalid_r;
    assign s_axi_wready = !s_r.w_have_r && !s_r.bvalid_r;
    assign s_axi_arready = !s_r.rvalid_r;
    assign s_axi_bvalid = s_r.bvalid_r;
    assign s_axi_bresp = s_r.bresp_r;
    assign s_axi_rvalid = s_r.rvalid_r;
    assign s_axi_rdata = s_r.rdata_r;
    assign s_axi_rresp = s_r.rresp_r;

    // ----------------------------------------------------------------
    // interrupt requests
    // ----------------------------------------------------------------
    assign periodic_tick_interrupt = s_r.tick_flag_r && s_r.tick_irq_enable_r
                                     && !cpu_irq_mask;
    assign pll_settle_interrupt = s_r.pll_settle_change_flag_r && s_r.pll_settle_irq_enable_r
                                  && !cpu_irq_mask;
    assign oscillator_change_interrupt = s_r.oscillator_change_flag_r
                                         && s_r.oscillator_change_irq_enable_r
                                         && !cpu_irq_mask;
    assign supply_droop_interrupt = s_r.supply_droop_flag_r && s_r.supply_droop_irq_enable_r
                                    && !cpu_irq_mask;
    assign periodic_timer_interrupt = s_r.periodic_timer_flag_r
                                      && s_r.periodic_timer_irq_enable_r
                                      && !cpu_irq_mask;
    assign periodic_waveform_pin = s_r.periodic_waveform_r;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic do_write;
        logic [2:0] widx;
        logic [31:0] wd;
        logic [31:0] clr;
        logic tick_restart;
        logic tick_step;
        logic tick_run;
        logic tick_end;
        logic pt_start;
        logic pt_step;
        logic pt_end;
        logic osc_up_now;
        logic droop_now;
        logic [2:0] ridx;
        logic [31:0] rd;
        s_nxt = s_r;
        do_write = 1'b0;
        widx = 3'h7;
        wd = 32'h0000_0000;
        clr = 32'h0000_0000;
        tick_restart = 1'b0;
        pt_start = 1'b0;
        rd = 32'h0000_0000;
        ridx = reg_index(s_axi_araddr);
        tick_step = 1'b0;
        tick_run = 1'b0;
        tick_end = 1'b0;
        pt_step = 1'b0;
        pt_end = 1'b0;
        osc_up_now = 1'b0;
        droop_now = 1'b0;

        // ----------------------------------------------------------------
        // write channels, taken in either order
        // ----------------------------------------------------------------
        if (s_axi_awvalid && s_axi_awready) begin
            s_nxt.aw_have_r = 1'b1;
            s_nxt.aw_addr_r = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_nxt.w_have_r = 1'b1;
            s_nxt.w_data_r = s_axi_wdata;
            s_nxt.w_strb_r = s_axi_wstrb;
        end
        if (s_r.aw_have_r && s_r.w_have_r) begin
            do_write = 1'b1;
            widx = reg_index(s_r.aw_addr_r);
            s_nxt.aw_have_r = 1'b0;
            s_nxt.w_have_r = 1'b0;
            s_nxt.bvalid_r = 1'b1;
            s_nxt.bresp_r = (widx == 3'h7) ? `CPI_RESP_DECERR : `CPI_RESP_OKAY;
        end
        if (s_r.bvalid_r && s_axi_bready) begin
            s_nxt.bvalid_r = 1'b0;
        end

        // ----------------------------------------------------------------
        // register writes
        // ----------------------------------------------------------------
        if (do_write) begin
            case (widx)
                3'h0: begin
                    wd = merge({25'h0, s_r.ext_oscillator_enable_r, s_r.osc_keep_in_stop_r,
                                s_r.pseudo_stop_select_r, s_r.tick_clock_select_r,
                                s_r.oscillator_change_irq_enable_r,
                                s_r.pll_settle_irq_enable_r, s_r.tick_irq_enable_r},
                               s_r.w_data_r, s_r.w_strb_r);
                    s_nxt.tick_irq_enable_r = wd[`CPI_EN_TICK];
                    s_nxt.pll_settle_irq_enable_r = wd[`CPI_EN_PLL];
                    s_nxt.oscillator_change_irq_enable_r = wd[`CPI_EN_OSC];
                    s_nxt.tick_clock_select_r = wd[`CPI_EN_TICK_SEL];
                    s_nxt.pseudo_stop_select_r = wd[`CPI_EN_PSTOP];
                    s_nxt.osc_keep_in_stop_r = wd[`CPI_EN_OSC_KEEP];
                    s_nxt.ext_oscillator_enable_r = wd[`CPI_EN_OSC_ON];
                end
                3'h1: begin
                    // only lanes that are written can clear flags
                    clr = merge(32'h0000_0000, s_r.w_data_r, s_r.w_strb_r);
                end
                3'h2: begin
                    wd = merge({16'h0, s_r.tick_period_r}, s_r.w_data_r, s_r.w_strb_r);
                    s_nxt.tick_period_r = wd[15:0];
                    tick_restart = 1'b1;
                end
                3'h3: begin
                    if (s_r.w_strb_r[0]) begin
                        s_nxt.supply_droop_irq_enable_r = s_r.w_data_r[0];
                    end
                end
                3'h4: begin
                    if (s_r.w_strb_r[0]) begin
                        s_nxt.periodic_timer_enable_r = s_r.w_data_r[`CPI_PT_ENABLE];
                        s_nxt.periodic_timer_irq_enable_r = s_r.w_data_r[`CPI_PT_IRQ_EN];
                        s_nxt.periodic_timer_pin_enable_r = s_r.w_data_r[`CPI_PT_PIN_EN];
                        pt_start = s_r.w_data_r[`CPI_PT_ENABLE]
                                   && !s_r.periodic_timer_enable_r;
                        if (!s_r.periodic_timer_enable_r) begin
                            s_nxt.periodic_timer_clock_select_r =
                                s_r.w_data_r[`CPI_PT_CLK_SEL];
                        end
                    end
                    if (s_r.w_strb_r[1]) begin
                        s_nxt.autonomous_clock_trim_r =
                            s_r.w_data_r[`CPI_PT_TRIM_HI:`CPI_PT_TRIM_LO];
                    end
                end
                3'h5: begin
                    if (!s_r.periodic_timer_enable_r) begin
                        wd = merge({16'h0, s_r.periodic_timer_period_r}, s_r.w_data_r,
                                   s_r.w_strb_r);
                        s_nxt.periodic_timer_period_r = wd[15:0];
                    end
                end
                default: begin
                end
            endcase
        end

        // ----------------------------------------------------------------
        // tick counter
        // ----------------------------------------------------------------
        tick_step = s_r.tick_clock_select_r ? external_oscillator_tick
                                            : internal_rc_tick;
        tick_run = !stop_mode || (s_r.pseudo_stop_select_r && s_r.tick_clock_select_r
                                  && s_r.osc_keep_in_stop_r);
        tick_end = 1'b0;
        if (tick_restart) begin
            s_nxt.tick_count_r = 16'h0000;
        end else if (tick_step && tick_run) begin
            if (s_r.tick_count_r >= s_r.tick_period_r) begin
                tick_end = 1'b1;
                s_nxt.tick_count_r = 16'h0000;
            end else begin
                s_nxt.tick_count_r = s_r.tick_count_r + 16'h0001;
            end
        end

        // oscillator up follows lock while the oscillator is enabled, lost on config change or full stop
        osc_up_now = s_r.ext_oscillator_enable_r && s_r.pll_lock_seen_r && pll_lock
                     && !pll_config_change && !full_stop_mode;
        s_nxt.oscillator_up_status_r = osc_up_now;
        s_nxt.pll_lock_seen_r = pll_lock;

        // supply droop status, held outside full performance mode
        droop_now = s_r.supply_droop_status_r;
        if (full_performance_mode) begin
            if (supply_below_assert) begin
                droop_now = 1'b1;
            end else if (supply_above_deassert) begin
                droop_now = 1'b0;
            end
        end
        s_nxt.supply_droop_status_r = droop_now;

        // ----------------------------------------------------------------
        // periodic timer; bus clock stands for aclk here
        // ----------------------------------------------------------------
        pt_step = s_r.periodic_timer_clock_select_r ? autonomous_rc_tick
                                                     : !bus_clock_stopped;
        pt_end = 1'b0;
        if (pt_start) begin
            // counting starts on the next step, so startup delay only trims period one
            s_nxt.ptimer_count_r = s_r.periodic_timer_period_r;
        end else if (!s_r.periodic_timer_enable_r) begin
            s_nxt.ptimer_count_r = s_r.periodic_timer_period_r;
        end else if (pt_step) begin
            if (s_r.ptimer_count_r == 16'h0000) begin
                pt_end = 1'b1;
                s_nxt.ptimer_count_r = s_r.periodic_timer_period_r;
            end else begin
                s_nxt.ptimer_count_r = s_r.ptimer_count_r - 16'h0001;
            end
        end
        if (!(s_r.periodic_timer_enable_r && s_r.periodic_timer_pin_enable_r)) begin
            s_nxt.periodic_waveform_r = 1'b0;
        end else if (pt_end) begin
            s_nxt.periodic_waveform_r = !s_r.periodic_waveform_r;
        end

        // ----------------------------------------------------------------
        // flags: a set in the clearing cycle wins
        // ----------------------------------------------------------------
        s_nxt.tick_flag_r = (s_r.tick_flag_r && !clr[`CPI_FL_TICK]) || tick_end;
        s_nxt.pll_settle_change_flag_r = (s_r.pll_settle_change_flag_r && !clr[`CPI_FL_PLL])
                                         || (pll_lock != s_r.pll_lock_seen_r);
        s_nxt.oscillator_change_flag_r = (s_r.oscillator_change_flag_r && !clr[`CPI_FL_OSC])
                                         || (osc_up_now != s_r.oscillator_up_status_r);
        s_nxt.supply_droop_flag_r = (s_r.supply_droop_flag_r && !clr[`CPI_FL_DROOP])
                                    || (droop_now != s_r.supply_droop_status_r);
        s_nxt.periodic_timer_flag_r = (s_r.periodic_timer_flag_r && !clr[`CPI_FL_PTIMER])
                                      || pt_end;

        // ----------------------------------------------------------------
        // read channel
        // ----------------------------------------------------------------
        case (ridx)
            3'h0: rd = {25'h0, s_r.ext_oscillator_enable_r, s_r.osc_keep_in_stop_r,
                        s_r.pseudo_stop_select_r, s_r.tick_clock_select_r,
                        s_r.oscillator_change_irq_enable_r, s_r.pll_settle_irq_enable_r,
                        s_r.tick_irq_enable_r};
            3'h1: rd = {21'h0, s_r.supply_droop_status_r, s_r.oscillator_up_status_r,
                        s_r.pll_lock_seen_r, 3'h0, s_r.periodic_timer_flag_r,
                        s_r.supply_droop_flag_r, s_r.oscillator_change_flag_r,
                        s_r.pll_settle_change_flag_r, s_r.tick_flag_r};
            3'h2: rd = {16'h0, s_r.tick_period_r};
            3'h3: rd = {31'h0, s_r.supply_droop_irq_enable_r};
            3'h4: rd = {18'h0, s_r.autonomous_clock_trim_r, 4'h0,
                        s_r.periodic_timer_pin_enable_r, s_r.periodic_timer_irq_enable_r,
                        s_r.periodic_timer_clock_select_r, s_r.periodic_timer_enable_r};
            3'h5: rd = {16'h0, s_r.periodic_timer_period_r};
            default: rd = 32'h0000_0000;
        endcase
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid_r = 1'b1;
            s_nxt.rdata_r = rd;
            s_nxt.rresp_r = (ridx == 3'h7) ? `CPI_RESP_DECERR : `CPI_RESP_OKAY;
        end else if (s_r.rvalid_r && s_axi_rready) begin
            s_nxt.rvalid_r = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            s_r.tick_period_r <= `CPI_RST_TICK_PERIOD;
            s_r.periodic_timer_period_r <= `CPI_RST_PTIMER_PERIOD;
            s_r.ptimer_count_r <= `CPI_RST_PTIMER_PERIOD;
            s_r.autonomous_clock_trim_r <= `CPI_RST_TRIM;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

// ==== test/cpi_irq_props.sv ====
// Purpose: port-level checks of cpi_irq
// Assumes: one aclk domain, synchronous active-low reset
// Notes: bound to every cpi_irq instance below
`timescale 1ns/10ps
module cpi_irq_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic cpu_irq_mask,
    input wire logic periodic_tick_interrupt,
    input wire logic pll_settle_interrupt,
    input wire logic oscillator_change_interrupt,
    input wire logic supply_droop_interrupt,
    input wire logic periodic_timer_interrupt
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_mask_gates_all: assert property (cpu_irq_mask |-> !(periodic_tick_interrupt
        | pll_settle_interrupt | oscillator_change_interrupt | supply_droop_interrupt
        | periodic_timer_interrupt)) else $error("request seen while masked");
    a_pll_flag_sticky: assert property (pll_settle_interrupt && !cpu_irq_mask
        ##1 !cpu_irq_mask && !s_axi_bvalid |-> pll_settle_interrupt) else $error("lock flag lost");
    a_droop_flag_sticky: assert property (supply_droop_interrupt && !cpu_irq_mask
        ##1 !cpu_irq_mask && !s_axi_bvalid |-> supply_droop_interrupt) else $error("droop flag lost");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready
        && !(s_axi_rvalid && s_axi_arready)) else $error("ready while busy");
endmodule
bind cpi_irq cpi_irq_props u_props (.*);

// ==== test/tb_top.sv ====
// Purpose: self-checking bench for cpi_irq
// Assumes: all slow clock ticks share one enable toggling every aclk
// Notes: table rows cover reset values and register access, then hand tests
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_top;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] v; logic [1:0] r;} cpi_row_t;
    logic aclk, aresetn, awv, wv, bry, arv, rry, stp, fstp, fperf, lock, pcc, below, above, msk;
    logic awr, wrd, bv, arr, rv, irq_t, irq_p, irq_o, irq_d, irq_a, pin, p;
    logic tk = 1'h0;
    logic [1:0] br, rr, gr;
    logic [31:0] wd, rd, got;
    logic [7:0] awa, ara;
    logic [3:0] ws;
    int error_cnt, n_tests, n;
    // timer period written as 3, then enabled; the later period write must be ignored
    cpi_row_t tbl [11] = '{{1'h0, 8'h00, 32'h0, 2'h0}, {1'h0, 8'h08, 32'hFFFF, 2'h0},
        {1'h0, 8'h10, 32'h2000, 2'h0}, {1'h0, 8'h14, 32'hFFFF, 2'h0},
        {1'h0, 8'h18, 32'h0, 2'h3}, {1'h1, 8'h18, 32'h1, 2'h3}, {1'h1, 8'h14, 32'h3, 2'h0},
        {1'h1, 8'h10, 32'hF, 2'h0}, {1'h1, 8'h14, 32'h5, 2'h0}, {1'h0, 8'h14, 32'h3, 2'h0},
        {1'h0, 8'h10, 32'hF, 2'h0}};
    cpi_irq uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .internal_rc_tick(tk),
        .external_oscillator_tick(tk), .autonomous_rc_tick(tk), .bus_clock_stopped(stp),
        .stop_mode(stp), .full_stop_mode(fstp), .full_performance_mode(fperf), .pll_lock(lock),
        .pll_config_change(pcc), .supply_below_assert(below), .supply_above_deassert(above),
        .cpu_irq_mask(msk), .periodic_tick_interrupt(irq_t), .pll_settle_interrupt(irq_p),
        .oscillator_change_interrupt(irq_o), .supply_droop_interrupt(irq_d),
        .periodic_timer_interrupt(irq_a), .periodic_waveform_pin(pin));
    initial begin
        aclk = 1'h0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) tk <= ~tk;
    // ready and response are sampled mid-cycle, where they are settled for the next edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ha, hw, hb;
        begin
            hb = 1'h0;
            awa <= a; wd <= d; ws <= 4'hF; awv <= 1'h1; wv <= 1'h1; bry <= 1'h1;
            while (!hb) begin
                @(negedge aclk);
                ha = awv && awr; hw = wv && wrd; hb = bv; gr = br;
                @(posedge aclk);
                if (ha) awv <= 1'h0;
                if (hw) wv <= 1'h0;
            end
            bry <= 1'h0;
            @(posedge aclk);
        end
    endtask
    task rdx(input logic [7:0] a);
        logic ha, hb;
        begin
            hb = 1'h0;
            ara <= a; arv <= 1'h1; rry <= 1'h1;
            while (!hb) begin
                @(negedge aclk);
                ha = arv && arr; hb = rv; got = rd; gr = rr;
                @(posedge aclk);
                if (ha) arv <= 1'h0;
            end
            rry <= 1'h0;
            @(posedge aclk);
        end
    endtask
    task stop_test;
        $display("errors %0d in %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #30000;
        error_cnt++;
        stop_test;
    end
    initial begin
        {aresetn, awv, wv, bry, arv, rry, stp, fstp, fperf, lock, pcc, below, above, msk} = '0;
        {awa, ara, wd, ws, error_cnt, n_tests} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        foreach (tbl[i]) begin
            if (tbl[i].w) begin
                wr(tbl[i].a, tbl[i].v);
                `CHK(gr, tbl[i].r)
            end else begin
                rdx(tbl[i].a);
                `CHK(got, tbl[i].v)
                `CHK(gr, tbl[i].r)
            end
        end
        for (int k = 0; k < 2; k++) begin
            p = pin; n = 0;
            while (pin === p && n < 60) begin
                @(negedge aclk);
                n++;
            end
        end
        `CHK(n, 8)
        `CHK(irq_a, 1'h1)
        @(posedge aclk) msk <= 1'h1;
        @(negedge aclk) `CHK(irq_a, 1'h0)
        @(posedge aclk) msk <= 1'h0;
        wr(8'h00, 32'h2);
        lock <= 1'h1;
        repeat (3) @(negedge aclk);
        `CHK(irq_p, 1'h1)
        @(posedge aclk) wr(8'h04, 32'h0);
        @(negedge aclk) `CHK(irq_p, 1'h1)
        @(posedge aclk) wr(8'h04, 32'h2);
        @(negedge aclk) `CHK(irq_p, 1'h0)
        @(posedge aclk) wr(8'h0C, 32'h1);
        fperf <= 1'h1;
        below <= 1'h1;
        repeat (3) @(negedge aclk);
        `CHK(irq_d, 1'h1)
        @(posedge aclk) wr(8'h04, 32'h8);
        @(negedge aclk) `CHK(irq_d, 1'h0)
        @(posedge aclk) below <= 1'h0;
        above <= 1'h1;
        repeat (3) @(negedge aclk);
        `CHK(irq_d, 1'h1)
        // tick ends every 4 selected ticks; clear, then time the next end
        @(posedge aclk) wr(8'h00, 32'h3);
        wr(8'h08, 32'h3);
        n = 0;
        while (irq_t !== 1'h1 && n < 20) begin
            @(negedge aclk);
            n++;
        end
        `CHK(irq_t, 1'h1)
        @(posedge aclk) wr(8'h04, 32'h1);
        n = 0;
        while (irq_t !== 1'h1 && n < 20) begin
            @(negedge aclk);
            n++;
        end
        `CHK(n, 4)
        @(posedge aclk) stp <= 1'h1;
        wr(8'h04, 32'h1);
        repeat (20) @(negedge aclk);
        `CHK(irq_t, 1'h0)
        rdx(8'h04);
        `CHK(got[9], 1'h0)
        @(posedge aclk) wr(8'h00, 32'h47);
        @(negedge aclk) `CHK(irq_o, 1'h1)
        @(posedge aclk) wr(8'h04, 32'h4);
        @(negedge aclk) `CHK(irq_o, 1'h0)
        @(posedge aclk) pcc <= 1'h1;
        repeat (2) @(negedge aclk);
        `CHK(irq_o, 1'h1)
        stop_test;
    end
endmodule
